//--- cod_pkg.sv
// Purpose: Shared constants and types for the 8-bit core decode and execute subset.
// Assumes: One byte-wide memory port, one access per clock.
// Notes: Opcodes, flag positions, cycle counts and reset values live here only.
`default_nettype none
package cod_pkg;
  localparam logic [7:0] OP_PAGE_Y = 8'h18;
  localparam logic [7:0] OP_ADD_ACC = 8'h1b;
  localparam logic [7:0] OP_ADD_B_X = 8'h3a;
  localparam logic [7:0] OP_CMP_ACC = 8'h11;
  localparam logic [7:0] OP_CLR_C = 8'h0c;
  localparam logic [7:0] OP_CLR_I = 8'h0e;
  localparam logic [7:0] OP_CLR_V = 8'h0a;
  localparam logic [7:0] OP_SHL_A = 8'h48;
  localparam logic [7:0] OP_SHL_B = 8'h58;
  localparam logic [7:0] OP_SHR_A = 8'h47;
  localparam logic [7:0] OP_CLR_A = 8'h4f;
  localparam logic [7:0] OP_CLR_B = 8'h5f;
  localparam logic [7:0] OP_BCC = 8'h24;
  localparam logic [7:0] OP_BCS = 8'h25;
  localparam logic [7:0] OP_BNE = 8'h26;
  localparam logic [7:0] OP_BEQ = 8'h27;
  localparam logic [7:0] OP_BVC = 8'h28;
  localparam logic [7:0] OP_BVS = 8'h29;
  localparam logic [7:0] OP_BSR = 8'h8d;
  localparam logic [7:0] OP_CLEAR_MASK_BITS_D = 8'h15;
  localparam logic [7:0] OP_SET_MASK_BITS_D = 8'h14;
  localparam logic [7:0] OP_CLEAR_MASK_BITS_X = 8'h1d;
  localparam logic [7:0] OP_SET_MASK_BITS_X = 8'h1c;
  // Memory read-modify-write group: low nibble selects the operation.
  localparam logic [3:0] LO_SHL = 4'h8;
  localparam logic [3:0] LO_SHR = 4'h7;
  localparam logic [3:0] LO_CLR = 4'hf;
  localparam logic [3:0] HI_RMW_X = 4'h6;
  localparam logic [3:0] HI_RMW_E = 4'h7;
  // Accumulator/memory group: low nibble selects the operation.
  localparam logic [3:0] LO_AND = 4'h4;
  localparam logic [3:0] LO_BIT = 4'h5;
  localparam logic [3:0] LO_ADC = 4'h9;
  localparam logic [3:0] LO_ADD = 4'hb;
  localparam logic [3:0] LO_ADD_SIXTEEN_BIT = 4'h3;
  // Flag positions in the condition code byte.
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam int FLG_X = 6;
  localparam int FLG_S = 7;
  localparam logic [7:0] CCR_RST = 8'hd0;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00ff;
  // Cycle counts.
  localparam logic [3:0] CYC_INH = 4'h2;
  localparam logic [3:0] CYC_ABX = 4'h3;
  localparam logic [3:0] CYC_REL = 4'h3;
  localparam logic [3:0] CYC_BSR = 4'h6;
  localparam logic [3:0] CYC_RMW = 4'h6;
  localparam logic [3:0] CYC_MSK_D = 4'h6;
  localparam logic [3:0] CYC_MSK_X = 4'h7;
  localparam logic [3:0] CYC_IMM = 4'h2;
  localparam logic [3:0] CYC_DIR = 4'h3;
  localparam logic [3:0] CYC_EXT = 4'h4;
  localparam logic [3:0] CYC_IDX = 4'h4;
  localparam logic [3:0] CYC_WIDE = 4'h2;
  localparam logic [3:0] CYC_PAGE = 4'h1;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cod_bus_s;
endpackage
`default_nettype wire

//--- cod_core.sv
// Purpose: Decode and execute for a subset of the 8-bit core instruction set.
// Assumes: Memory answers a read combinationally in the same cycle (MEM_RDATA).
// Notes: Each instruction spends at least its documented cycle count before a last cycle that
// commits registers. Unknown opcodes execute as a 4-cycle no-op, except 6x and 7x, which read 1 or 2 operand bytes and take 5 or 6.
// Short forms still pass through fetch, execute, wait and commit, so they overrun their count.
// What this block does
// (RULE1) Opcode 1B adds B into A in 2 cycles, updating H N Z V C.
// (RULE2) 3A adds zero-extended B to X in 3; 18 3A to Y in 4; no flags.
// (RULE3) Add-with-carry into A: 89/99/A9/18 A9, 2/3/4/5 cycles, H N Z V C.
// (RULE4) Add-with-carry into B: C9/D9/F9/E9/18 E9, 2/3/4/4/5 cycles.
// (RULE5) Add to A: 8B/9B/BB/AB/18 AB, 2/3/4/4/5 cycles, H N Z V C.
// (RULE6) Add to B: CB/DB/FB/EB/18 EB, 2/3/4/4/5 cycles, H N Z V C.
// (RULE7) Sixteen-bit add into D: C3/D3/F3/E3/18 E3, 4 to 7 cycles, N Z V C.
// (RULE8) AND into A: 84/94/B4/A4/18 A4; N Z set, V cleared, C kept.
// (RULE9) AND into B: C4/D4/F4/E4/18 E4; N Z set, V cleared, C kept.
// (RULE10) Shift memory left: 78/68/18 68 in 6/6/7; bit 7 to carry.
// (RULE11) Shift A left 48, B left 58, 2 cycles, N Z V C.
// (RULE12) Shift right 77/67/18 67 and 47; bit 7 kept, bit 0 to carry.
// (RULE13) Clear mask bits: 15/1D/18 1D in 6/7/8; N Z set, V cleared.
// (RULE14) Set mask bits: 14/1C/18 1C in 6/7/8; N Z set, V cleared.
// (RULE15) Branches 24 C clear, 25 C set, 27 Z set, 26 Z clear; 3 cycles.
// (RULE16) Branch 28 on V clear, 29 on V set; 3 cycles.
// (RULE17) Bit test ANDs accumulator with memory, no store; N Z, V cleared.
// (RULE18) 8D branches to subroutine in 6 cycles, stacking return address.
// (RULE19) 11 compares A minus B in 2 cycles, N Z V C.
// (RULE20) 0C clears C, 0E clears I, 0A clears V; 2 cycles each.
// (RULE21) Clear memory 7F/6F or A 4F, B 5F; N0 Z1 V0 C0.
// (RULE22) Unnamed flags keep value; 18 selects Y in place of X, as index base or as the 3A target.
`default_nettype none
module cod_core
  import cod_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [7:0] MEM_RDATA,
  output cod_bus_s MEM_BUS,
  output logic INSN_DONE,
  output logic [7:0] ACC_A,
  output logic [7:0] ACC_B,
  output logic [15:0] IDX_X,
  output logic [15:0] IDX_Y,
  output logic [15:0] PROG_CNT,
  output logic [7:0] CCR
);
  typedef enum logic [3:0] {
    ST_FETCH = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_DONE = 4'b1000
  } cod_state_e;

  cod_state_e st_q, st_d;
  logic [7:0] a_q, b_q, ccr_q, op_q, opd_q, msk_q;
  logic [15:0] x_q, y_q, pc_q, sp_q, ea_q, w_q;
  logic page_q;
  logic [3:0] cnt_q;
  logic [2:0] ph_q;

  // Opcode classification.
  wire [3:0] hi = op_q[7:4];
  wire [3:0] lo = op_q[3:0];
  wire acc_grp = op_q[7] & (lo == LO_AND || lo == LO_BIT || lo == LO_ADC || lo == LO_ADD ||
    (lo == LO_ADD_SIXTEEN_BIT && op_q[6]));
  wire [1:0] mode = op_q[5:4];
  wire is_b = op_q[6];
  wire is_wide = acc_grp & (lo == LO_ADD_SIXTEEN_BIT) & is_b;
  wire is_rmw = (hi == HI_RMW_X || hi == HI_RMW_E) & (lo == LO_SHL || lo == LO_SHR || lo == LO_CLR);
  wire is_msk = (op_q == OP_CLEAR_MASK_BITS_D) | (op_q == OP_SET_MASK_BITS_D) | (op_q == OP_CLEAR_MASK_BITS_X) | (op_q == OP_SET_MASK_BITS_X);
  wire is_br = (op_q >= OP_BCC) & (op_q <= OP_BVS);
  wire is_bsr = op_q == OP_BSR;
  wire idx_mode = acc_grp ? (mode == 2'b10) : ((hi == HI_RMW_X) | (op_q == OP_CLEAR_MASK_BITS_X) | (op_q == OP_SET_MASK_BITS_X));
  wire ext_mode = acc_grp ? (mode == 2'b11) : (hi == HI_RMW_E);
  wire dir_mode = acc_grp ? (mode == 2'b01) : (op_q == OP_CLEAR_MASK_BITS_D) | (op_q == OP_SET_MASK_BITS_D);
  wire imm_mode = acc_grp & (mode == 2'b00);
  // Operand byte count before the data access.
  wire [2:0] nopd = (is_br | is_bsr | idx_mode | dir_mode) ? 3'd1 : ext_mode ? 3'd2 :
    (imm_mode & is_wide) ? 3'd2 : imm_mode ? 3'd1 : 3'd0;
  wire [15:0] base = page_q ? y_q : x_q; // RULE22

  // Cycle budget per instruction.
  wire [3:0] acc_cyc = imm_mode ? CYC_IMM : dir_mode ? CYC_DIR : CYC_EXT;
  wire [3:0] cyc0 = (op_q == OP_ADD_B_X) ? CYC_ABX : // RULE2
    is_br ? CYC_REL : is_bsr ? CYC_BSR : // RULE15 RULE16 RULE18
    is_rmw ? ((lo == LO_CLR || hi == HI_RMW_E || hi == HI_RMW_X) ? CYC_RMW : CYC_INH) : // RULE10 RULE12 RULE21
    is_msk ? (dir_mode ? CYC_MSK_D : CYC_MSK_X) : // RULE13 RULE14
    acc_grp ? (is_wide ? acc_cyc + CYC_WIDE : acc_cyc) : CYC_INH; // RULE3 RULE7 RULE8
  wire [3:0] cyc_tot = page_q ? 4'(cyc0 + CYC_PAGE) : cyc0;

  // Arithmetic.
  wire [7:0] acc = is_b ? b_q : a_q;
  wire use_c = lo == LO_ADC;
  wire [8:0] sum8 = {1'b0, acc} + {1'b0, opd_q} + {8'h00, use_c & ccr_q[FLG_C]};
  wire [4:0] hsum = {1'b0, acc[3:0]} + {1'b0, opd_q[3:0]} + {4'h0, use_c & ccr_q[FLG_C]};
  wire v8 = (acc[7] == opd_q[7]) & (sum8[7] != acc[7]);
  wire [15:0] d_val = {a_q, b_q};
  wire [16:0] sum16 = {1'b0, d_val} + {1'b0, w_q};
  wire v16 = (d_val[15] == w_q[15]) & (sum16[15] != d_val[15]);
  wire [8:0] aba = {1'b0, a_q} + {1'b0, b_q};
  wire [4:0] abah = {1'b0, a_q[3:0]} + {1'b0, b_q[3:0]};
  wire abav = (a_q[7] == b_q[7]) & (aba[7] != a_q[7]);
  wire [8:0] cba = {1'b0, a_q} - {1'b0, b_q};
  wire cbav = (a_q[7] != b_q[7]) & (cba[7] != a_q[7]);
  wire [7:0] andr = acc & opd_q;
  // Shift source: memory operand or accumulator.
  wire [7:0] shs = (hi == 4'h4) ? a_q : (hi == 4'h5) ? b_q : opd_q;
  wire [7:0] shl = {shs[6:0], 1'b0};
  wire [7:0] shr = {shs[7], shs[7:1]};
  // Shift result, shared by the accumulator forms and the memory write.
  wire [7:0] sh_res = (lo == LO_SHL) ? shl : shr;
  wire [7:0] mskr = (op_q[0]) ? (opd_q & ~msk_q) : (opd_q | msk_q);
  wire br_take = (op_q == OP_BCC) ? ~ccr_q[FLG_C] : (op_q == OP_BCS) ? ccr_q[FLG_C] :
    (op_q == OP_BNE) ? ~ccr_q[FLG_Z] : (op_q == OP_BEQ) ? ccr_q[FLG_Z] :
    (op_q == OP_BVC) ? ~ccr_q[FLG_V] : ccr_q[FLG_V];
  wire [15:0] rel = {{8{opd_q[7]}}, opd_q};

  // Bus request of the current cycle.
  wire fetch_op = st_q == ST_FETCH;
  wire opd_rd = (st_q == ST_EXEC) & (ph_q < nopd);
  wire [15:0] ea_now = idx_mode ? 16'(base + {8'h00, ea_q[7:0]}) : ea_q;
  wire data_rd = (st_q == ST_EXEC) & (ph_q == nopd) & ~imm_mode & (acc_grp | is_msk |
    (is_rmw & hi[3:1] == 3'b011));
  // A sixteen-bit memory operand reads its low byte from the next address one cycle later.
  wire data_rd2 = (st_q == ST_EXEC) & is_wide & ~imm_mode & (ph_q == 3'(nopd + 3'd1));
  wire msk_rd = (st_q == ST_EXEC) & is_msk & (ph_q == 3'(nopd + 3'd1));
  wire wr_now = (st_q == ST_WAIT) & (cnt_q == 4'h1) & ((is_rmw & hi[3:1] == 3'b011) | is_msk);
  wire bsr_wr = (st_q == ST_WAIT) & is_bsr & (cnt_q == 4'h3 || cnt_q == 4'h2);
  always_comb begin
    MEM_BUS = '0;
    if (fetch_op | opd_rd) begin
      MEM_BUS.addr = pc_q;
      MEM_BUS.rd = 1'b1;
    end else if (data_rd | data_rd2 | msk_rd) begin
      MEM_BUS.addr = msk_rd ? pc_q : data_rd2 ? ea_q : ea_now;
      MEM_BUS.rd = 1'b1;
    end else if (wr_now) begin
      MEM_BUS.addr = ea_q;
      MEM_BUS.wr = 1'b1;
      MEM_BUS.wdata = is_msk ? mskr : (lo == LO_CLR) ? 8'h00 : sh_res;
    end else if (bsr_wr) begin
      MEM_BUS.addr = sp_q;
      MEM_BUS.wr = 1'b1;
      MEM_BUS.wdata = (cnt_q == 4'h3) ? pc_q[7:0] : pc_q[15:8]; // RULE18
    end
  end

  wire go_wait = (st_q == ST_EXEC) & (ph_q >= 3'(nopd + (is_msk ? 3'd1 : 3'd0)))
    & ~data_rd & ~data_rd2 & ~msk_rd;
  // Cycles spent before the wait state, not counting an 18 prefix fetch; a form that has used its budget waits one cycle only.
  wire [3:0] cyc_used = 4'({1'b0, ph_q}) + 4'h2;
  wire [3:0] cnt_load = (cyc_tot > cyc_used) ? 4'(cyc_tot - cyc_used) : 4'h0;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_FETCH: st_d = (MEM_RDATA == OP_PAGE_Y && !page_q) ? ST_FETCH : ST_EXEC;
      ST_EXEC: st_d = go_wait ? ST_WAIT : ST_EXEC;
      ST_WAIT: st_d = (cnt_q <= 4'h1) ? ST_DONE : ST_WAIT;
      ST_DONE: st_d = ST_FETCH;
      default: st_d = ST_FETCH;
    endcase
  end

  // Flag and register results on commit.
  logic [7:0] ccr_n, a_n, b_n;
  logic [15:0] x_n, y_n, pc_n;
  always_comb begin
    ccr_n = ccr_q; // RULE22
    a_n = a_q;
    b_n = b_q;
    x_n = x_q;
    y_n = y_q;
    pc_n = pc_q;
    if (op_q == OP_ADD_ACC) begin
      a_n = aba[7:0]; // RULE1
      ccr_n[FLG_H] = abah[4];
      ccr_n[FLG_N] = aba[7];
      ccr_n[FLG_Z] = aba[7:0] == 8'h00;
      ccr_n[FLG_V] = abav;
      ccr_n[FLG_C] = aba[8];
    end else if (op_q == OP_ADD_B_X) begin
      if (page_q) y_n = y_q + {8'h00, b_q}; // RULE2
      else x_n = x_q + {8'h00, b_q};
    end else if (op_q == OP_CMP_ACC) begin
      ccr_n[FLG_N] = cba[7]; // RULE19
      ccr_n[FLG_Z] = cba[7:0] == 8'h00;
      ccr_n[FLG_V] = cbav;
      ccr_n[FLG_C] = cba[8];
    end else if (op_q == OP_CLR_C) begin
      ccr_n[FLG_C] = 1'b0; // RULE20
    end else if (op_q == OP_CLR_I) begin
      ccr_n[FLG_I] = 1'b0; // RULE20
    end else if (op_q == OP_CLR_V) begin
      ccr_n[FLG_V] = 1'b0; // RULE20
    end else if (is_br) begin
      if (br_take) pc_n = pc_q + rel; // RULE15 RULE16
    end else if (is_bsr) begin
      pc_n = pc_q + rel; // RULE18
    end else if (is_wide) begin
      {a_n, b_n} = sum16[15:0]; // RULE7
      ccr_n[FLG_N] = sum16[15];
      ccr_n[FLG_Z] = sum16[15:0] == 16'h0000;
      ccr_n[FLG_V] = v16;
      ccr_n[FLG_C] = sum16[16];
    end else if (acc_grp & (lo == LO_ADC || lo == LO_ADD)) begin
      if (is_b) b_n = sum8[7:0]; // RULE3 RULE4 RULE5 RULE6
      else a_n = sum8[7:0];
      ccr_n[FLG_H] = hsum[4];
      ccr_n[FLG_N] = sum8[7];
      ccr_n[FLG_Z] = sum8[7:0] == 8'h00;
      ccr_n[FLG_V] = v8;
      ccr_n[FLG_C] = sum8[8];
    end else if (acc_grp) begin
      if (lo == LO_AND && is_b) b_n = andr; // RULE9
      else if (lo == LO_AND) a_n = andr; // RULE8
      ccr_n[FLG_N] = andr[7]; // RULE17
      ccr_n[FLG_Z] = andr == 8'h00;
      ccr_n[FLG_V] = 1'b0;
    end else if (is_msk) begin
      ccr_n[FLG_N] = mskr[7]; // RULE13 RULE14
      ccr_n[FLG_Z] = mskr == 8'h00;
      ccr_n[FLG_V] = 1'b0;
    end else if ((is_rmw & (lo == LO_CLR)) | (op_q == OP_CLR_A) | (op_q == OP_CLR_B)) begin
      // Memory and accumulator clears share one flag result.
      if (hi == 4'h4) a_n = 8'h00; // RULE21
      if (hi == 4'h5) b_n = 8'h00;
      ccr_n[FLG_N] = 1'b0;
      ccr_n[FLG_Z] = 1'b1;
      ccr_n[FLG_V] = 1'b0;
      ccr_n[FLG_C] = 1'b0;
    end else if (is_rmw | op_q == OP_SHL_A | op_q == OP_SHL_B | op_q == OP_SHR_A) begin
      if (hi == 4'h4) a_n = sh_res; // RULE10 RULE11 RULE12
      if (hi == 4'h5) b_n = sh_res;
      ccr_n[FLG_C] = (lo == LO_SHL) ? shs[7] : shs[0];
      ccr_n[FLG_N] = sh_res[7];
      ccr_n[FLG_Z] = sh_res == 8'h00;
      ccr_n[FLG_V] = sh_res[7] ^ ((lo == LO_SHL) ? shs[7] : shs[0]);
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= ST_FETCH;
      {a_q, b_q, op_q, opd_q, msk_q} <= '0;
      {x_q, y_q, ea_q, w_q} <= '0;
      ccr_q <= CCR_RST;
      pc_q <= PC_RST;
      sp_q <= SP_RST;
      page_q <= 1'b0;
      cnt_q <= '0;
      ph_q <= '0;
    end else begin
      st_q <= st_d;
      if (fetch_op) begin
        pc_q <= pc_q + 16'h0001;
        if (MEM_RDATA == OP_PAGE_Y && !page_q) page_q <= 1'b1; // RULE22
        else op_q <= MEM_RDATA;
        ph_q <= '0;
        ea_q <= '0;
      end
      if (st_q == ST_EXEC) begin
        ph_q <= ph_q + 3'd1;
        if (opd_rd) begin
          pc_q <= pc_q + 16'h0001;
          if (imm_mode & is_wide) w_q <= {w_q[7:0], MEM_RDATA};
          else if (imm_mode | is_br | is_bsr) opd_q <= MEM_RDATA;
          ea_q <= {ea_q[7:0], MEM_RDATA};
        end
        if (data_rd) begin
          ea_q <= ea_now + 16'h0001;
          if (is_wide) w_q[15:8] <= MEM_RDATA;
          else opd_q <= MEM_RDATA;
          if (!is_wide) ea_q <= ea_now;
        end else if (data_rd2) begin
          w_q[7:0] <= MEM_RDATA;
        end
        if (msk_rd) begin
          msk_q <= MEM_RDATA;
          pc_q <= pc_q + 16'h0001;
        end
        if (go_wait) cnt_q <= cnt_load;
      end
      if (st_q == ST_WAIT) begin
        cnt_q <= cnt_q - 4'h1;
        if (bsr_wr) sp_q <= sp_q - 16'h0001;
      end
      if (st_q == ST_DONE) begin
        {a_q, b_q, ccr_q, x_q, y_q} <= {a_n, b_n, ccr_n, x_n, y_n};
        pc_q <= pc_n;
        page_q <= 1'b0;
      end
    end
  end

  assign INSN_DONE = st_q == ST_DONE;
  assign ACC_A = a_q;
  assign ACC_B = b_q;
  assign IDX_X = x_q;
  assign IDX_Y = y_q;
  assign PROG_CNT = pc_q;
  assign CCR = ccr_q;
endmodule
`default_nettype wire

//--- cod_mem.sv
// Purpose: Byte memory that answers the core's program and data bus.
// Assumes: 256 bytes; the address wraps on its low byte.
// Notes: With no read made the data lines show the inverse of the last read.
`default_nettype none
module cod_mem
  import cod_pkg::*;
(
  input wire logic REF_CLK,
  input wire cod_bus_s MEM_BUS,
  output logic [7:0] MEM_RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [256];
  logic [7:0] last_q = 8'h00;
  assign MEM_RDATA = MEM_BUS.rd ? mem_q[MEM_BUS.addr[7:0]] : ~last_q;
  always @(posedge REF_CLK) begin
    if (MEM_BUS.rd) last_q <= MEM_RDATA;
    if (MEM_BUS.wr) mem_q[MEM_BUS.addr[7:0]] <= MEM_BUS.wdata;
  end
endmodule
`default_nettype wire

//--- cod_core_checker.sv
// Purpose: Concurrent checks on the ports of the core.
// Assumes: One clock domain and an asynchronous active-low reset.
// Notes: A helper register keeps the byte read in the first fetch cycle of each instruction.
`default_nettype none
module cod_core_checker
  import cod_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic [7:0] MEM_RDATA,
  input wire cod_bus_s MEM_BUS,
  input wire logic INSN_DONE,
  input wire logic [7:0] ACC_A,
  input wire logic [7:0] ACC_B,
  input wire logic [15:0] IDX_X,
  input wire logic [15:0] IDX_Y,
  input wire logic [15:0] PROG_CNT,
  input wire logic [7:0] CCR
);
  timeunit 1ns;
  timeprecision 1ns;
  logic fetch_q;
  logic [7:0] op_q;
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      fetch_q <= 1'b1;
      op_q <= 8'h00;
    end else begin
      fetch_q <= INSN_DONE;
      op_q <= fetch_q ? MEM_RDATA : op_q;
    end
  end
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  sequence s_commit(logic [7:0] op);
    INSN_DONE && op_q == op;
  endsequence
  a_reset_fetch: assert property ($rose(RST_B) |-> MEM_BUS.rd && MEM_BUS.addr == PC_RST && CCR == CCR_RST)
    else $error("first fetch after reset is wrong");
  a_done_fetch: assert property (INSN_DONE |=> MEM_BUS.rd && !MEM_BUS.wr && MEM_BUS.addr == PROG_CNT)
    else $error("no opcode fetch after a commit");
  a_regs_stand: assert property (!INSN_DONE |=> $stable(ACC_A) && $stable(ACC_B) && $stable(CCR))
    else $error("register changed outside a commit");
  a_clear_carry: assert property (s_commit(OP_CLR_C) |=> CCR == ($past(CCR) & 8'hfe))
    else $error("carry clear altered the wrong flags");
  a_clear_imask: assert property (s_commit(OP_CLR_I) |=> CCR == ($past(CCR) & 8'hef))
    else $error("mask clear altered the wrong flags");
  a_clear_ovf: assert property (s_commit(OP_CLR_V) |=> CCR == ($past(CCR) & 8'hfd))
    else $error("overflow clear altered the wrong flags");
  a_clear_acc: assert property (s_commit(OP_CLR_A) |=> ACC_A == 8'h00 && CCR == {$past(CCR[7:4]), 4'h4})
    else $error("accumulator clear result is wrong");
  a_shift_b: assert property (s_commit(OP_SHL_B) |=> ACC_B == ($past(ACC_B) << 1) && CCR[FLG_C] == $past(ACC_B[7]))
    else $error("left shift of b is wrong");
  a_add_bx: assert property (s_commit(OP_ADD_B_X) |=> IDX_X == $past(IDX_X) + {8'h00, ACC_B} && $stable(CCR))
    else $error("index add is wrong");
endmodule
bind cod_core cod_core_checker i_cod_core_checker (.REF_CLK(REF_CLK), .RST_B(RST_B), .MEM_RDATA(MEM_RDATA),
  .MEM_BUS(MEM_BUS), .INSN_DONE(INSN_DONE), .ACC_A(ACC_A), .ACC_B(ACC_B), .IDX_X(IDX_X), .IDX_Y(IDX_Y),
  .PROG_CNT(PROG_CNT), .CCR(CCR));
`default_nettype wire

//--- cod_core_tb.sv
// Purpose: Self-checking bench that runs short programs on the core.
// Assumes: The memory model answers every read in the same cycle.
// Notes: Results are judged just after the last counted instruction commits.
`default_nettype none
module cod_core_tb
  import cod_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] mem_rdata;
  cod_bus_s mem_bus;
  logic insn_done;
  logic [7:0] acc_a;
  logic [7:0] acc_b;
  logic [15:0] idx_x;
  logic [15:0] idx_y;
  logic [15:0] prog_cnt;
  logic [7:0] ccr;
  int mismatches = 0;
  int num_checks = 0;
  cod_core i_cod_core (.REF_CLK(ref_clk), .RST_B(rst_b), .MEM_RDATA(mem_rdata), .MEM_BUS(mem_bus),
    .INSN_DONE(insn_done), .ACC_A(acc_a), .ACC_B(acc_b), .IDX_X(idx_x), .IDX_Y(idx_y),
    .PROG_CNT(prog_cnt), .CCR(ccr));
  cod_mem i_cod_mem (.REF_CLK(ref_clk), .MEM_BUS(mem_bus), .MEM_RDATA(mem_rdata));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Resets the core, loads a program at 0000 and waits for n commits.
  task automatic run_prog(input logic [7:0] prog[$], input int n);
    int seen;
    int guard;
    seen = 0;
    guard = 0;
    @(posedge ref_clk);
    #1 rst_b = 1'b0;
    for (int k = 0; k < 256; k++) begin
      i_cod_mem.mem_q[k] = (k < prog.size()) ? prog[k] : 8'h01;
    end
    @(posedge ref_clk);
    #1 rst_b = 1'b1;
    while (seen < n && guard < 300) begin
      @(posedge ref_clk);
      guard++;
      if (insn_done === 1'b1) seen++;
    end
    #1;
    check("instructions done", 16'(n), 16'(seen));
    if (seen < n) complete_run();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_add();
    run_prog('{8'h8b, 8'h7f, 8'hcb, 8'h01, 8'h1b}, 3);
    check("acc_a", 16'h0080, acc_a);
    check("acc_b", 16'h0001, acc_b);
    check("ccr", 16'h00fa, ccr);
    run_prog('{8'h8b, 8'h7f, 8'h14, 8'h80, 8'hf0}, 2);
    check("acc_a", 16'h007f, acc_a);
    check("mem 80", 16'h00f1, i_cod_mem.mem_q[8'h80]);
  endtask
  task automatic t_adc_and();
    run_prog('{8'h8b, 8'hff, 8'h89, 8'h01, 8'h84, 8'h0f}, 3);
    check("acc_a", 16'h0000, acc_a);
    check("ccr", 16'h00f5, ccr);
  endtask
  task automatic t_b_forms();
    run_prog('{8'hc9, 8'h10, 8'hd9, 8'h90, 8'hfb, 8'h00, 8'h90, 8'hc4, 8'h3f, 8'h58, 8'h4f}, 6);
    check("acc_b", 16'h0024, acc_b);
    check("ccr", 16'h00d4, ccr);
  endtask
  task automatic t_shift();
    run_prog('{8'h8b, 8'h81, 8'h48}, 2);
    check("acc_a", 16'h0002, acc_a);
    check("ccr", 16'h00d3, ccr);
    run_prog('{8'h8b, 8'hc1, 8'h47}, 2);
    check("acc_a", 16'h00e0, acc_a);
    check("ccr", 16'h00d9, ccr);
  endtask
  task automatic t_mem_ops();
    run_prog('{8'h14, 8'h80, 8'hf0, 8'h15, 8'h80, 8'h01, 8'h78, 8'h00, 8'h80, 8'h7f, 8'h00, 8'h81}, 4);
    check("mem 80", 16'h00e0, i_cod_mem.mem_q[8'h80]);
    check("mem 81", 16'h0000, i_cod_mem.mem_q[8'h81]);
    check("ccr", 16'h00d4, ccr);
  endtask
  task automatic t_branch();
    run_prog('{8'h24, 8'h02, 8'h8b, 8'h01, 8'h25, 8'h02, 8'h8b, 8'h02, 8'h27, 8'h02, 8'h8b, 8'h04,
      8'h26, 8'h02, 8'h8b, 8'h08, 8'h28, 8'h02, 8'h8b, 8'h10, 8'h29, 8'h02, 8'h8b, 8'h20}, 9);
    check("acc_a", 16'h0026, acc_a);
    check("prog_cnt", 16'h0018, prog_cnt);
    run_prog('{8'h8b, 8'hff, 8'h8b, 8'h01, 8'h25, 8'h02, 8'h8b, 8'h40, 8'h27, 8'h02, 8'h8b, 8'h40,
      8'h8b, 8'h7f, 8'h8b, 8'h01, 8'h29, 8'h02, 8'h8b, 8'h40}, 7);
    check("acc_a", 16'h0080, acc_a);
    check("prog_cnt", 16'h0014, prog_cnt);
  endtask
  task automatic t_cmp_flags();
    run_prog('{8'h8b, 8'h7f, 8'hcb, 8'hff, 8'h11, 8'h0c, 8'h0a, 8'h0e}, 6);
    check("acc_a", 16'h007f, acc_a);
    check("ccr", 16'h00c8, ccr);
  endtask
  task automatic t_index_bsr();
    run_prog('{8'hcb, 8'h05, 8'h3a, 8'h18, 8'h3a, 8'h8d, 8'h02}, 4);
    check("idx_x", 16'h0005, idx_x);
    check("idx_y", 16'h0005, idx_y);
    check("ccr", 16'h00d0, ccr);
    check("stack low", 16'h0007, i_cod_mem.mem_q[8'hff]);
    check("stack high", 16'h0000, i_cod_mem.mem_q[8'hfe]);
    check("prog_cnt", 16'h0009, prog_cnt);
  endtask
  task automatic t_wide();
    run_prog('{8'hc3, 8'h12, 8'h34, 8'hc3, 8'hf0, 8'h00, 8'h85, 8'hf0}, 3);
    check("acc_a", 16'h0002, acc_a);
    check("acc_b", 16'h0034, acc_b);
    check("ccr", 16'h00d5, ccr);
    run_prog('{8'hd3, 8'h02, 8'h12, 8'h34}, 1);
    check("acc_a", 16'h0012, acc_a);
    check("acc_b", 16'h0034, acc_b);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    repeat (8) @(posedge ref_clk);
    t_add();
    t_adc_and();
    t_b_forms();
    t_shift();
    t_mem_ops();
    t_branch();
    t_cmp_flags();
    t_index_bsr();
    t_wide();
    complete_run();
  end
endmodule
`default_nettype wire
